/* File: rtl/sdmds_pkg.sv */
package sdmds_pkg;
  // digit geometry of one word
  localparam int          NDIG     = 24;            // digits per word, scale of the position counter
  localparam int          DW       = 4;             // bits per bcd digit
  localparam int          WBITS    = NDIG * DW;     // bits per register
  localparam logic [4:0]  POS_LAST = 5'h17;         // position counter wraps 0 -> 23
  localparam logic [4:0]  POS_ZERO = 5'h00;         // lowest digit position
  localparam logic [3:0]  DIG_NINE = 4'h9;          // largest decimal digit
  localparam logic [3:0]  DIG_ZERO = 4'h0;          // zero digit
  localparam logic [4:0]  DIG_TEN  = 5'h0a;         // decimal carry threshold

  // wishbone word indices (byte address = 4 * index)
  localparam logic [5:0]  IDX_CTRL = 6'h00;         // key entry, write only
  localparam logic [5:0]  IDX_STAT = 6'h01;         // sequencer state, read only
  localparam logic [5:0]  IDX_ACC  = 6'h02;         // accumulator, three words
  localparam logic [5:0]  IDX_ENT  = 6'h05;         // entry register, three words
  localparam logic [5:0]  IDX_MQ   = 6'h08;         // multiplier-quotient, three words
  localparam logic [5:0]  NWORDS   = 6'h03;         // words per data register

  // function keys, written to the control word bits [2:0]
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_MADD = 3'h1,                                 // multiply_add_key
    OP_CMUL = 3'h2,                                 // clear_and_multiply_key
    OP_MSUB = 3'h3,                                 // multiply_subtract_key
    OP_DIV  = 3'h4                                  // divide key
  } sdmds_op_t;

  // phase counter, one bit changes on every step of the usual path except the final digit-load to idle
  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_INIT   = 3'h1,                               // init_phase
    PH_ATEST  = 3'h3,                               // align_test_phase
    PH_ASHIFT = 3'h2,                               // align_shift_phase
    PH_LOAD   = 3'h7,                               // digit_load_phase
    PH_ACCUM  = 3'h6,                               // accumulate_phase
    PH_PASS1  = 3'h4,                               // passing_phase_one
    PH_PASS2  = 3'h5                                // passing_phase_two
  } sdmds_phase_t;
endpackage

/* File: rtl/sdmds_seq.sv */
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
// Operation
// RL1 - multiply-subtract adds one plus nines complement
// RL2 - init sets position to units digit
// RL3 - init sets initial-pass flag
// RL4 - init advances to align-test after one word
// RL5 - align-test: top nonzero digit loads, else shifts
// RL6 - align-shift: position up, multiplicand left, retest
// RL7 - digit-load puts selected multiplier digit in repeat
// RL8 - digit-load shifts right unless initial pass
// RL9 - digit-load decrements position, clears initial-pass flag
// RL10 - zero repeat count stays in digit-load
// RL11 - position zero at digit-load sets clear flag
// RL12 - nonzero repeat count goes to accumulate
// RL13 - accumulate adds, decrements repeat, repeats while nonzero
// RL14 - passing phases then back to digit-load
// RL15 - position mod 24; 23 with clear ends
// RL16 - clear-and-multiply clears accumulator in init
// RL17 - division starts position at units digit
// RL18 - division shifts divisor left, counting position up
// RL19 - division subtracts until negative, restores once
// RL20 - non-negative subtractions form the quotient digit
// RL21 - after restore remainder shifts left, repeat
// RL22 - remainder shift decrements the position counter
// RL23 - subtraction presets the carry-in flag
// RL24 - nines complement inverts each digit
// RL25 - quotient digit stored, repeat counter cleared
// RL26 - after end idle, result held
module sdmds_seq
  import sdmds_pkg::*;
#(
  parameter logic [4:0] UNITS_POS = 5'h00           // digit position of the units digit
) (
  input  wire logic        I_CLOCK,                 // 50 MHz system clock
  input  wire logic        I_RST_N,                 // synchronous reset, active low
  input  wire logic        I_WB_CYC,                // wishbone cycle
  input  wire logic        I_WB_STB,                // wishbone strobe
  input  wire logic        I_WB_WE,                 // wishbone write enable
  input  wire logic [7:0]  I_WB_ADR,                // wishbone byte address
  input  wire logic [3:0]  I_WB_SEL,                // wishbone byte lanes
  input  wire logic [31:0] I_WB_DAT,                // wishbone write data
  output logic             O_WB_ACK,                // wishbone acknowledge
  output logic [31:0]      O_WB_DAT,                // wishbone read data
  output logic             O_BUSY                   // a routine is running
);

  ////////////////////////////////////////////////////////////////////////////
  // digit arithmetic helpers

  // decimal add with carry in; bit WBITS is the carry out of the top digit
  function automatic logic [WBITS:0] bcd_add(input logic [WBITS-1:0] a, input logic [WBITS-1:0] b,
                                             input logic cin);
    logic [WBITS-1:0] r;
    logic             c;
    logic [4:0]       s;
    r = '0;
    c = cin;
    for (int i = 0; i < NDIG; i++) begin
      s = {1'b0, a[i*DW +: DW]} + {1'b0, b[i*DW +: DW]} + {4'h0, c};
      c = (s >= DIG_TEN);
      r[i*DW +: DW] = c ? 4'(s - DIG_TEN) : s[3:0];
    end
    return {c, r};
  endfunction
  // nines complement, digit by digit; no carries are formed
  function automatic logic [WBITS-1:0] nines(input logic [WBITS-1:0] x);
    logic [WBITS-1:0] r;
    r = '0;
    for (int i = 0; i < NDIG; i++) begin
      r[i*DW +: DW] = DIG_NINE - x[i*DW +: DW]; // see RL24
    end
    return r;
  endfunction
  // one decimal place left (times ten)
  function automatic logic [WBITS-1:0] shl(input logic [WBITS-1:0] x);
    return {x[WBITS-DW-1:0], DIG_ZERO};
  endfunction
  // digit at a position
  function automatic logic [3:0] dig(input logic [WBITS-1:0] x, input logic [4:0] p);
    return x[p*DW +: DW];
  endfunction
  // index of the highest nonzero digit, zero for a zero word
  function automatic logic [4:0] msd(input logic [WBITS-1:0] x);
    logic [4:0] r;
    r = POS_ZERO;
    for (int i = 0; i < NDIG; i++) begin
      if (x[i*DW +: DW] != DIG_ZERO) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction
  // position counter runs modulo 24
  function automatic logic [4:0] pos_dec(input logic [4:0] p);
    return (p == POS_ZERO) ? POS_LAST : 5'(p - 5'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  sdmds_phase_t     phase_ff, nxt_phase;            // phase counter
  sdmds_op_t        op_ff, nxt_op;                  // latched function key
  logic [WBITS-1:0] acc_ff, nxt_acc;                // accumulator
  logic [WBITS-1:0] ent_ff, nxt_ent;                // entry register (multiplicand, divisor)
  logic [WBITS-1:0] mq_ff, nxt_mq;                  // multiplier-quotient register
  logic [4:0]       pos_ff, nxt_pos;                // digit position, selected_digit_strobe slot
  logic [3:0]       rep_ff, nxt_rep;                // repeat counter
  logic             initial_pass_flag_ff, nxt_initial_pass_flag;
  logic             clear_flag_ff, nxt_clear_flag;  // armed for termination
  logic             carry_in_flag_ff, nxt_carry_in_flag;
  logic             ack_ff, nxt_ack;                // bus acknowledge
  logic [31:0]      dat_ff, nxt_dat;                // bus read data
  logic             busy_ff, nxt_busy;              // busy output
  logic             req;                            // new bus request this cycle
  logic [5:0]       widx;                           // word index
  logic [WBITS:0]   sum;                            // adder result with carry
  logic             term;                           // end of routine sensed
  logic [3:0]       seldig;                         // multiplier digit at position
  assign req    = I_WB_CYC & I_WB_STB & ~ack_ff;
  assign widx   = I_WB_ADR[7:2];
  assign term   = clear_flag_ff && (pos_ff == POS_LAST);
  assign seldig = dig(mq_ff, pos_ff);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and sequencer next state

  always_comb begin
    logic [31:0]      wmask;
    wmask                 = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
    nxt_phase             = phase_ff;
    nxt_op                = op_ff;
    nxt_acc               = acc_ff;
    nxt_ent               = ent_ff;
    nxt_mq                = mq_ff;
    nxt_pos               = pos_ff;
    nxt_rep               = rep_ff;
    nxt_initial_pass_flag = initial_pass_flag_ff;
    nxt_clear_flag        = clear_flag_ff;
    nxt_carry_in_flag     = carry_in_flag_ff;
    nxt_ack               = req;                    // one-cycle answer to every request
    nxt_dat               = '0;                     // unmapped reads answer zero
    sum                   = '0;

    // reads: registers stand still while idle, a busy read sees a snapshot
    if (req && !I_WB_WE) begin
      if (widx == IDX_STAT) begin
        nxt_dat = {16'h0000, 3'(phase_ff), 3'(op_ff), pos_ff, rep_ff, busy_ff};
      end else if (widx >= IDX_ACC && widx < IDX_ACC + NWORDS) begin
        nxt_dat = acc_ff[32*(widx - IDX_ACC) +: 32];
      end else if (widx >= IDX_ENT && widx < IDX_ENT + NWORDS) begin
        nxt_dat = ent_ff[32*(widx - IDX_ENT) +: 32];
      end else if (widx >= IDX_MQ && widx < IDX_MQ + NWORDS) begin
        nxt_dat = mq_ff[32*(widx - IDX_MQ) +: 32];
      end
    end

    case (phase_ff)
      PH_IDLE: begin
        // idle-only writes, committed at the edge where the master samples ack
        if (I_WB_CYC && I_WB_STB && I_WB_WE && ack_ff) begin
          if (widx == IDX_CTRL && I_WB_SEL[0]) begin
            if (I_WB_DAT[2:0] inside {OP_MADD, OP_CMUL, OP_MSUB, OP_DIV}) begin
              nxt_op    = sdmds_op_t'(I_WB_DAT[2:0]);
              nxt_phase = PH_INIT;
            end
          end else if (widx >= IDX_ACC && widx < IDX_ACC + NWORDS) begin
            nxt_acc[32*(widx - IDX_ACC) +: 32] = (acc_ff[32*(widx - IDX_ACC) +: 32] & ~wmask) | (I_WB_DAT & wmask);
          end else if (widx >= IDX_ENT && widx < IDX_ENT + NWORDS) begin
            nxt_ent[32*(widx - IDX_ENT) +: 32] = (ent_ff[32*(widx - IDX_ENT) +: 32] & ~wmask) | (I_WB_DAT & wmask);
          end else if (widx >= IDX_MQ && widx < IDX_MQ + NWORDS) begin
            nxt_mq[32*(widx - IDX_MQ) +: 32] = (mq_ff[32*(widx - IDX_MQ) +: 32] & ~wmask) | (I_WB_DAT & wmask);
          end
        end
      end
      PH_INIT: begin
        nxt_pos               = UNITS_POS;          // see RL2 see RL17
        nxt_initial_pass_flag = 1'b1;               // see RL3
        nxt_clear_flag        = 1'b0;
        nxt_rep               = DIG_ZERO;
        nxt_carry_in_flag     = (op_ff == OP_MSUB) || (op_ff == OP_DIV); // see RL23
        if (op_ff == OP_CMUL) begin
          nxt_acc = '0;                             // see RL16
        end
        if (op_ff == OP_DIV) begin
          nxt_mq = '0;                              // quotient slots start empty
        end
        nxt_phase = PH_ATEST;                       // see RL4
      end
      PH_ATEST: begin
        // the top position also stops the multiply search; a zero divisor with a dividend above 9 never aligns and never stops
        if (op_ff == OP_DIV) begin
          if (msd(ent_ff) >= msd(acc_ff) || dig(ent_ff, POS_LAST) != DIG_ZERO) begin // see RL18
            nxt_phase = PH_LOAD;
          end else begin
            nxt_phase = PH_ASHIFT;
          end
        end else if (msd(mq_ff) <= pos_ff || pos_ff == POS_LAST) begin // see RL5
          nxt_phase = PH_LOAD;
        end else begin
          nxt_phase = PH_ASHIFT;
        end
      end
      PH_ASHIFT: begin
        nxt_pos   = 5'(pos_ff + 5'h01);             // see RL6 see RL18
        nxt_ent   = shl(ent_ff);
        nxt_phase = PH_ATEST;
      end
      PH_LOAD: begin
        if (term) begin
          nxt_phase = PH_IDLE;                      // see RL15 see RL26
        end else if (op_ff == OP_DIV) begin
          // subtract by complement; carry out means a non-negative remainder
          if (pos_ff == POS_ZERO) begin
            nxt_clear_flag = 1'b1;                  // see RL11
          end
          sum     = bcd_add(acc_ff, nines(ent_ff), carry_in_flag_ff); // see RL19
          nxt_acc = sum[WBITS-1:0];
          if (sum[WBITS]) begin
            nxt_rep = 4'(rep_ff + 4'h1);            // see RL20
          end else begin
            nxt_phase = PH_ACCUM;
          end
        end else begin
          nxt_rep = seldig;                         // see RL7
          if (!initial_pass_flag_ff) begin
            nxt_ent = {DIG_ZERO, ent_ff[WBITS-1:DW]}; // see RL8
          end
          nxt_pos               = pos_dec(pos_ff);  // see RL9
          nxt_initial_pass_flag = 1'b0;             // see RL9
          if (pos_ff == POS_ZERO) begin
            nxt_clear_flag = 1'b1;                  // see RL11
          end
          if (seldig != DIG_ZERO) begin
            nxt_phase = PH_ACCUM;                   // see RL12
          end
          // a zero digit simply stays here another word, see RL10
        end
      end
      PH_ACCUM: begin
        if (op_ff == OP_DIV) begin
          sum       = bcd_add(acc_ff, ent_ff, 1'b0); // undo the last subtraction, see RL19
          nxt_acc   = sum[WBITS-1:0];
          nxt_phase = PH_PASS1;
        end else begin
          if (op_ff == OP_MSUB) begin
            sum = bcd_add(acc_ff, nines(ent_ff), carry_in_flag_ff); // see RL1
          end else begin
            sum = bcd_add(acc_ff, ent_ff, 1'b0);    // see RL13
          end
          nxt_acc = sum[WBITS-1:0];
          nxt_rep = 4'(rep_ff - 4'h1);              // see RL13
          if (rep_ff == 4'h1) begin
            nxt_phase = PH_PASS1;                   // see RL14
          end
        end
      end
      PH_PASS1: begin
        if (op_ff == OP_DIV) begin
          nxt_mq[pos_ff*DW +: DW] = rep_ff;         // see RL25
          nxt_rep                 = DIG_ZERO;       // see RL25
          nxt_pos                 = pos_dec(pos_ff); // see RL22
          nxt_acc                 = shl(acc_ff);    // see RL21
        end
        nxt_phase = PH_PASS2;                       // see RL14
      end
      PH_PASS2: begin
        nxt_phase = PH_LOAD;                        // see RL14 see RL21
      end
      default: begin
        nxt_phase = PH_IDLE;
      end
    endcase
    nxt_busy = (nxt_phase != PH_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      phase_ff             <= PH_IDLE;
      op_ff                <= OP_NONE;
      acc_ff               <= '0;
      ent_ff               <= '0;
      mq_ff                <= '0;
      pos_ff               <= POS_ZERO;
      rep_ff               <= DIG_ZERO;
      initial_pass_flag_ff <= 1'b0;
      clear_flag_ff        <= 1'b0;
      carry_in_flag_ff     <= 1'b0;
      ack_ff               <= 1'b0;
      dat_ff               <= '0;
      busy_ff              <= 1'b0;
    end else begin
      phase_ff             <= nxt_phase;
      op_ff                <= nxt_op;
      acc_ff               <= nxt_acc;
      ent_ff               <= nxt_ent;
      mq_ff                <= nxt_mq;
      pos_ff               <= nxt_pos;
      rep_ff               <= nxt_rep;
      initial_pass_flag_ff <= nxt_initial_pass_flag;
      clear_flag_ff        <= nxt_clear_flag;
      carry_in_flag_ff     <= nxt_carry_in_flag;
      ack_ff               <= nxt_ack;
      dat_ff               <= nxt_dat;
      busy_ff              <= nxt_busy;
    end
  end

  assign O_WB_ACK = ack_ff;
  assign O_WB_DAT = dat_ff;
  assign O_BUSY   = busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_init_next; // see RL4
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_INIT |=> phase_ff == PH_ATEST;
  endproperty
  a_init_next: assert property (p_init_next) else $error("init did not move to align test"); // see RL4
  property p_init_pos; // see RL2
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_INIT |=> pos_ff == UNITS_POS && initial_pass_flag_ff;
  endproperty
  a_init_pos: assert property (p_init_pos) else $error("init did not set position and flag"); // see RL2
  property p_shift; // see RL6
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      phase_ff == PH_ASHIFT |=> pos_ff == 5'($past(pos_ff) + 5'h01) && phase_ff == PH_ATEST;
  endproperty
  a_shift: assert property (p_shift) else $error("align shift wrong"); // see RL6
  property p_load_mul; // see RL9
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_LOAD && op_ff != OP_DIV && !term
      |=> !initial_pass_flag_ff && pos_ff == pos_dec($past(pos_ff)) && rep_ff == dig(mq_ff, $past(pos_ff));
  endproperty
  a_load_mul: assert property (p_load_mul) else $error("digit load wrong"); // see RL9
  property p_zero_stay; // see RL10
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_LOAD && op_ff != OP_DIV && !term
      && seldig == DIG_ZERO |=> phase_ff == PH_LOAD;
  endproperty
  a_zero_stay: assert property (p_zero_stay) else $error("zero digit not skipped"); // see RL10
  property p_accum; // see RL13
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_ACCUM && op_ff != OP_DIV
      |=> rep_ff == 4'($past(rep_ff) - 4'h1);
  endproperty
  a_accum: assert property (p_accum) else $error("repeat count not decremented"); // see RL13
  property p_pass; // see RL14
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_PASS1 |=> phase_ff == PH_PASS2 ##1 phase_ff == PH_LOAD;
  endproperty
  a_pass: assert property (p_pass) else $error("passing phases out of order"); // see RL14
  property p_end; // see RL15
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_LOAD && term |=> phase_ff == PH_IDLE && !O_BUSY;
  endproperty
  a_end: assert property (p_end) else $error("routine did not end"); // see RL15
  property p_cmul; // see RL16
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_INIT && op_ff == OP_CMUL |=> acc_ff == '0;
  endproperty
  a_cmul: assert property (p_cmul) else $error("accumulator not cleared"); // see RL16
  property p_store; // see RL25
    @(posedge I_CLOCK) disable iff (!I_RST_N) phase_ff == PH_PASS1 && op_ff == OP_DIV
      |=> rep_ff == DIG_ZERO && dig(mq_ff, $past(pos_ff)) == $past(rep_ff);
  endproperty
  a_store: assert property (p_store) else $error("quotient digit not stored"); // see RL25
endmodule

/* File: dv/sdmds_wb_host.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// stands in for the key panel and register loader: classic wishbone master
module sdmds_wb_host (
  input  wire logic        i_clk,           // bench clock
  input  wire logic        i_ack,           // slave acknowledge
  input  wire logic [31:0] i_dat,           // slave read data
  output logic             o_cyc,           // bus cycle
  output logic             o_stb,           // bus strobe
  output logic             o_we,            // write enable
  output logic [7:0]       o_adr,           // byte address
  output logic [3:0]       o_sel,           // byte lanes
  output logic [31:0]      o_dat            // write data
);
  logic [3:0] sel_q = 4'hf;                 // byte lanes for the coming requests, set by the bench
  // quiet bus from time zero
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'hf;
    o_dat = 32'h0;
  end

  // one cycle; request held until ack is sampled high at an edge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_sel <= sel_q;
    o_dat <= dat;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 64);
    rd = i_dat;
    ok = (i_ack === 1'b1);
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we  <= 1'b0;
    // released lines flip so a stale value never passes for a held one
    o_adr <= ~adr;
    o_dat <= ~dat;
    @(posedge i_clk);
  endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
  import sdmds_pkg::*;
  logic        clk;                         // bench clock
  logic        rst_n;                       // reset, active low
  logic        cyc;                         // bus cycle
  logic        stb;                         // bus strobe
  logic        we;                          // bus direction
  logic        ack;                         // bus acknowledge
  logic        busy;                        // routine running
  logic [7:0]  adr;                         // byte address
  logic [3:0]  sel;                         // byte lanes
  logic [31:0] wdat;                        // write data
  logic [31:0] rdat;                        // read data
  logic [31:0] seed;                        // xorshift state
  logic [95:0] m24;                         // ten to the 24th
  int          miscompares;                 // mismatches
  int          n_compared;                  // comparisons

  sdmds_seq DUT (.I_CLOCK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
                 .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_ACK(ack),
                 .O_WB_DAT(rdat), .O_BUSY(busy));
  sdmds_wb_host host (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
                      .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));

  // 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // binary to 24 packed bcd digits, wraps at ten to the 24th
  function automatic logic [95:0] to_bcd(input logic [95:0] v);
    logic [95:0] r;
    for (int i = 0; i < NDIG; i++) begin
      r[i*DW +: DW] = 4'(v % 4'ha);
      v = v / 4'ha;
    end
    return r;
  endfunction
  // expected accumulator, or quotient for divide
  function automatic logic [95:0] model(sdmds_op_t op, logic [95:0] a, logic [95:0] x, logic [95:0] y);
    case (op)
      OP_MADD: return (a + x * y) % m24;
      OP_CMUL: return (x * y) % m24;
      OP_MSUB: return (a + m24 - (x * y) % m24) % m24;
      default: return a / y;
    endcase
  endfunction

  task automatic cmp(input logic [95:0] got, input logic [95:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    miscompares++;
    $display("BAD %0t %s timed out", $time, what);
    end_sim();
  endtask
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    host.xfer(w, {idx, 2'h0}, d, r, ok);
    if (!ok) hang("bus");
  endtask
  // data registers move as three words, low word first
  task automatic wr96(input logic [5:0] idx, input logic [95:0] v);
    logic [31:0] r;
    for (int i = 0; i < 3; i++) bus(1'b1, idx + 6'(i), v[i*32 +: 32], r);
  endtask
  task automatic rd96(input logic [5:0] idx, output logic [95:0] v);
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, idx + 6'(i), 32'h0, r);
      v[i*32 +: 32] = r;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // load operands, press a key, wait, check the result and the idle state
  task automatic run(input sdmds_op_t op, input logic [95:0] a, input logic [95:0] x, input logic [95:0] y);
    logic [95:0] got;
    logic [95:0] exp;
    logic [31:0] r;
    int n;
    exp = to_bcd(model(op, a, x, y));
    wr96(IDX_ACC, to_bcd(a));
    wr96(IDX_MQ, to_bcd(x));
    wr96(IDX_ENT, to_bcd(y));
    bus(1'b1, IDX_CTRL, {29'h0, op}, r);
    #1;
    cmp(96'(busy), 96'h1, "busy after key");
    // long routines only: a write landing mid-run must be ignored
    if (op == OP_DIV || x > 96'h9) bus(1'b1, IDX_ACC, 32'h5a5a5a5a, r);
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (busy !== 1'b0) hang("routine");
    if (op == OP_DIV) begin
      rd96(IDX_MQ, got);
      cmp(got, exp, "quotient");
    end else begin
      rd96(IDX_ACC, got);
      cmp(got, exp, "product");
    end
    bus(1'b0, IDX_STAT, 32'h0, r);
    cmp(96'({r[15:13], r[0]}), 96'h0, "idle state");
    if (op != OP_DIV) rd96(IDX_ACC, got);
    if (op != OP_DIV) cmp(got, exp, "result held");
  endtask

  initial begin
    logic [31:0] r;
    sdmds_op_t   op;
    seed = 32'h27;
    miscompares = 0;
    n_compared = 0;
    rst_n = 1'b0;
    m24 = 96'h1;
    for (int i = 0; i < NDIG; i++) m24 = m24 * 4'ha;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    cmp(96'({ack, busy}), 96'h0, "reset state");
    // empty word answers zero and swallows writes; key word reads zero
    bus(1'b1, 6'h20, 32'hffffffff, r);
    bus(1'b0, 6'h20, 32'h0, r);
    cmp(96'(r), 96'h0, "unmapped read");
    bus(1'b0, IDX_CTRL, 32'h0, r);
    cmp(96'(r), 96'h0, "key word read");
    bus(1'b1, IDX_CTRL, 32'h5, r);
    #1;
    cmp(96'(busy), 96'h0, "unused key ignored");
    // byte lanes: only lane 1 lands; a key without lane 0 is ignored
    bus(1'b1, IDX_ACC, 32'h11111111, r);
    host.sel_q = 4'h2;
    bus(1'b1, IDX_ACC, 32'hffffffff, r);
    host.sel_q = 4'he;
    bus(1'b1, IDX_CTRL, 32'h1, r);
    #1;
    cmp(96'(busy), 96'h0, "key without lane 0");
    host.sel_q = 4'hf;
    bus(1'b0, IDX_ACC, 32'h0, r);
    cmp(96'(r), 96'h1111ff11, "byte lanes");
    // corners: zero multiplier, borrow through every digit, top digit wrap, inner zeros
    run(OP_MADD, 96'h7b, 96'h0, 96'h4d);
    run(OP_MSUB, 96'h0, 96'h1, 96'h1);
    run(OP_CMUL, 96'h5, m24 / 4'ha, 96'hc);
    run(OP_MADD, 96'h63, 96'h1631d, 96'h22);
    run(OP_DIV, 96'h7, 96'h0, 96'h9);
    run(OP_DIV, 96'hf423f, 96'h0, 96'h3);
    for (int k = 0; k < 16; k++) begin
      op = sdmds_op_t'(3'(k % 4 + 1));
      run(op, 96'(rnd() % 32'h5f5e100), 96'(rnd() % 32'hf4240), 96'(rnd() % 32'hf4240 + 32'h1));
    end
    end_sim();
  end
endmodule
